// *** gpio_core_with_timer_pins.sv ***
// Pin core with plain pins and timer pins behind an AHB-Lite slave
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

module gpio_core_with_timer_pins #(
   parameter int NPIN = gpio_pkg::NPIN,
   parameter int NCH = gpio_pkg::NCH
) (
   input wire logic hclk,                       // Fast core clock
   input wire logic hresetn,                    // Async reset, active low
   input wire logic hsel,                       // Slave select
   input wire logic [31:0] haddr,               // Address
   input wire logic [1:0] htrans,               // Transfer type
   input wire logic hwrite,                     // Write when high
   input wire logic [2:0] hsize,                // Transfer size
   input wire logic [31:0] hwdata,              // Write data
   input wire logic hready,                     // Bus ready
   output logic hreadyout,                      // Slave ready
   output logic hresp,                          // Always OKAY
   output logic [31:0] hrdata,                  // Read data
   input wire logic [NPIN-1:0] pin_in,          // Pin levels
   output gpio_pkg::pin_drive_t pin_drive,      // Pin value, enable, mux select
   output logic irq                             // Plain-pin interrupt
);
   import gpio_pkg::*;

   // ------------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------------
   logic acc;
   logic wr_q;
   logic rd_pend_q;
   logic [11:0] addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;
   logic we;
   logic cpx_hit;
   logic [2:0] cpx_idx;

   assign acc = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'b11);
   assign we = wr_q;
   assign cpx_hit = (addr_q[11:8] == CPX_PAGE) && !addr_q[7];
   assign cpx_idx = addr_q[6:4];
   assign hreadyout = !rd_pend_q;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 12'h000;
      end else begin
         wr_q <= acc && hwrite;
         rd_pend_q <= acc && !hwrite;
         if (acc) begin
            addr_q <= haddr[11:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_pend_q) begin
         hrdata_q <= rd_mux;
      end
   end

   // ------------------------------------------------------------------
   // Power and block configuration
   // ------------------------------------------------------------------
   logic pwr_q;
   logic act_q;
   logic en_q;
   logic [1:0] div_sel_q;
   logic [7:0] slow_div_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_q <= 1'b0;
         act_q <= 1'b0;
      end else begin
         if (we && addr_q == OFS_POWER) begin
            pwr_q <= hwdata[PWR_REQ_BIT];
         end
         act_q <= pwr_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_q <= 1'b0;
         div_sel_q <= DIV_SEL_RST;
         slow_div_q <= SLOW_DIV_RST;
      end else if (we && addr_q == OFS_CONFIG) begin
         en_q <= hwdata[CFG_EN_BIT];
         div_sel_q <= hwdata[CFG_DIV_LSB +: 2];
         slow_div_q <= hwdata[CFG_SLOW_LSB +: 8];
      end
   end

   // ------------------------------------------------------------------
   // Clock enables: plain-pin tick and slow tick
   // ------------------------------------------------------------------
   logic [5:0] pp_cnt_q;
   logic [5:0] pp_tc;
   logic pp_tick;
   logic [7:0] slow_cnt_q;
   logic [7:0] slow_tc;
   logic slow_tick;

   always_comb begin
      case (div_sel_q)
         2'h0: pp_tc = DIV2_TC;
         2'h1: pp_tc = DIV4_TC;
         2'h2: pp_tc = DIV16_TC;
         default: pp_tc = DIV64_TC;
      endcase
   end

   assign pp_tick = en_q && (pp_cnt_q >= pp_tc);
   assign slow_tc = (slow_div_q < SLOW_DIV_MIN) ? SLOW_DIV_MIN : slow_div_q;
   assign slow_tick = (slow_cnt_q >= slow_tc);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pp_cnt_q <= 6'h00;
      end else if (!en_q || pp_tick) begin
         pp_cnt_q <= 6'h00;
      end else begin
         pp_cnt_q <= pp_cnt_q + 6'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slow_cnt_q <= 8'h00;
      end else if (slow_tick) begin
         slow_cnt_q <= 8'h00;
      end else begin
         slow_cnt_q <= slow_cnt_q + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // Pin input synchroniser
   // ------------------------------------------------------------------
   logic [NPIN-1:0] sync1_q;
   logic [NPIN-1:0] sync2_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // ------------------------------------------------------------------
   // Plain pins
   // ------------------------------------------------------------------
   logic [NPIN-1:0] out_q;
   logic [NPIN-1:0] oe_q;
   logic [NPIN-1:0] ien_q;
   logic [NPIN-1:0] ovr_q;
   logic [NPIN-1:0] istat_q;
   logic [NPIN-1:0] smp_q;
   logic [NPIN-1:0] drv_q;
   logic [NPIN-1:0] drv_oe_q;
   logic [NPIN-1:0] chg;
   logic [NPIN-1:0] clr;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_q <= '0;
         oe_q <= '0;
         ien_q <= '0;
         ovr_q <= '0;
      end else if (we) begin
         if (addr_q == OFS_OUT_LO) out_q[31:0] <= hwdata;
         if (addr_q == OFS_OUT_HI) out_q[NPIN-1:32] <= hwdata[NPIN-33:0];
         if (addr_q == OFS_OE_LO) oe_q[31:0] <= hwdata;
         if (addr_q == OFS_OE_HI) oe_q[NPIN-1:32] <= hwdata[NPIN-33:0];
         if (addr_q == OFS_IEN_LO) ien_q[31:0] <= hwdata;
         if (addr_q == OFS_IEN_HI) ien_q[NPIN-1:32] <= hwdata[NPIN-33:0];
         if (addr_q == OFS_OVR_LO) ovr_q[31:0] <= hwdata;
         if (addr_q == OFS_OVR_HI) ovr_q[NPIN-1:32] <= hwdata[NPIN-33:0];
      end
   end

   // Update and sample only on the plain-pin tick; drv_oe_q clears at once while the block is disabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         smp_q <= '0;
         drv_q <= '0;
         drv_oe_q <= '0;
      end else begin
         if (pp_tick) begin
            smp_q <= sync2_q;
            drv_q <= out_q;
            drv_oe_q <= oe_q;
         end
         if (!en_q) begin
            drv_oe_q <= '0;
         end
      end
   end

   assign chg = pp_tick ? ((sync2_q ^ smp_q) & ien_q) : '0;
   assign clr = (we && addr_q == OFS_ISTAT_LO) ? {{(NPIN-32){1'b0}}, hwdata} :
                (we && addr_q == OFS_ISTAT_HI) ? {hwdata[NPIN-33:0], 32'h0000_0000} : '0;

   // Write one to clear; a new change in the same cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         istat_q <= '0;
         irq <= 1'b0;
      end else begin
         istat_q <= (istat_q & ~clr) | chg;
         irq <= |istat_q;
      end
   end

   // ------------------------------------------------------------------
   // Timer pins
   // ------------------------------------------------------------------
   cpx_cfg_t cfg_q [NCH];
   logic [TW-1:0] thr_q [NCH];
   logic [TW-1:0] per_q [NCH];
   logic [NCH-1:0] cpx_in;

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [TW-1:0] tmr_q;
      logic armed_q;
      logic prev_q;
      logic sel;
      logic tick;
      logic hit;
      logic zero;
      logic rise;
      logic fall;

      assign sel = we && cpx_hit && (cpx_idx == 3'(c));
      assign cpx_in[c] = (int'(cfg_q[c].pin) < NPIN) ? sync2_q[cfg_q[c].pin] : 1'b0;
      assign tick = cfg_q[c].en && (cfg_q[c].clk_sel ? slow_tick : 1'b1);
      assign hit = (tmr_q == thr_q[c]);
      assign zero = (tmr_q == '0);
      assign rise = cfg_q[c].en && cpx_in[c] && !prev_q;
      assign fall = cfg_q[c].en && !cpx_in[c] && prev_q;

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            prev_q <= 1'b0;
         end else begin
            prev_q <= cpx_in[c];
         end
      end

      // Mode engine; a software write in the same cycle takes priority
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cfg_q[c] <= '0;
            tmr_q <= '0;
            thr_q[c] <= '0;
            per_q[c] <= PERIOD_RST;
            armed_q <= 1'b0;
         end else begin
            if (tick) begin
               tmr_q <= (tmr_q >= per_q[c]) ? '0 : tmr_q + 1'b1;
            end
            if (cfg_q[c].en) begin
               case (cfg_q[c].mode)
                  static_mode: begin
                     armed_q <= 1'b0;
                  end
                  toggle_mode: begin
                     if (tick && hit) cfg_q[c].out <= !cfg_q[c].out;
                  end
                  snapshot_counter_mode: begin
                     thr_q[c] <= tmr_q;
                  end
                  immediate_one_shot_mode: begin
                     if (!armed_q) begin
                        cfg_q[c].out <= !cfg_q[c].out;
                        tmr_q <= '0;
                        armed_q <= 1'b1;
                     end else if (tick && hit) begin
                        cfg_q[c].out <= !cfg_q[c].out;
                        cfg_q[c].mode <= static_mode;
                        armed_q <= 1'b0;
                     end
                  end
                  pulse_mode: begin
                     if (tick && !armed_q && zero) begin
                        cfg_q[c].out <= !cfg_q[c].out;
                        armed_q <= 1'b1;
                     end else if (tick && armed_q && hit) begin
                        cfg_q[c].out <= !cfg_q[c].out;
                        cfg_q[c].mode <= static_mode;
                        armed_q <= 1'b0;
                     end
                  end
                  pwm_mode: begin
                     if (tick && (zero || hit)) cfg_q[c].out <= !cfg_q[c].out;
                  end
                  low_width_mode: begin
                     if (fall) tmr_q <= '0;
                     if (rise) thr_q[c] <= tmr_q;
                  end
                  high_width_mode: begin
                     if (rise) tmr_q <= '0;
                     if (fall) thr_q[c] <= tmr_q;
                  end
                  low_width_once: begin
                     if (fall) begin
                        tmr_q <= '0;
                        armed_q <= 1'b1;
                     end else if (rise && armed_q) begin
                        thr_q[c] <= tmr_q;
                        cfg_q[c].mode <= static_mode;
                        armed_q <= 1'b0;
                     end
                  end
                  high_width_once: begin
                     if (rise) begin
                        tmr_q <= '0;
                        armed_q <= 1'b1;
                     end else if (fall && armed_q) begin
                        thr_q[c] <= tmr_q;
                        cfg_q[c].mode <= static_mode;
                        armed_q <= 1'b0;
                     end
                  end
                  fall_edge_capture_mode: begin
                     if (fall) thr_q[c] <= tmr_q;
                  end
                  rise_edge_capture_mode: begin
                     if (rise) thr_q[c] <= tmr_q;
                  end
                  any_edge_capture_mode: begin
                     if (rise || fall) thr_q[c] <= tmr_q;
                  end
                  fall_edge_single_capture: begin
                     if (fall) begin
                        thr_q[c] <= tmr_q;
                        cfg_q[c].mode <= static_mode;
                     end
                  end
                  rise_edge_single_capture: begin
                     if (rise) begin
                        thr_q[c] <= tmr_q;
                        cfg_q[c].mode <= static_mode;
                     end
                  end
                  any_edge_single_capture: begin
                     if (rise || fall) begin
                        thr_q[c] <= tmr_q;
                        cfg_q[c].mode <= static_mode;
                     end
                  end
                  default: begin
                     armed_q <= 1'b0;
                  end
               endcase
            end
            if (sel && addr_q[3:0] == OFS_CPX_STATUS) begin
               cfg_q[c].en <= hwdata[ST_EN_BIT];
               cfg_q[c].clk_sel <= hwdata[ST_CLK_BIT];
               cfg_q[c].out <= hwdata[ST_OUT_BIT];
               cfg_q[c].oe <= hwdata[ST_OE_BIT];
               cfg_q[c].mode <= mode_t'(hwdata[ST_MODE_LSB +: 4]);
               cfg_q[c].pin <= hwdata[ST_PIN_LSB +: 6];
               armed_q <= 1'b0;
            end
            if (sel && addr_q[3:0] == OFS_CPX_TIMER) tmr_q <= hwdata[TW-1:0];
            if (sel && addr_q[3:0] == OFS_CPX_THRESH) thr_q[c] <= hwdata[TW-1:0];
            if (sel && addr_q[3:0] == OFS_CPX_PERIOD) per_q[c] <= hwdata[TW-1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Pin drive merge: an enabled timer pin owns its physical pin
   // ------------------------------------------------------------------
   pin_drive_t drive_d;

   always_comb begin
      drive_d.out = drv_q;
      drive_d.oe = drv_oe_q;
      drive_d.sel = ovr_q;
      for (int c = 0; c < NCH; c++) begin
         for (int p = 0; p < NPIN; p++) begin
            if (cfg_q[c].en && cfg_q[c].pin == 6'(p)) begin
               drive_d.out[p] = cfg_q[c].out;
               drive_d.oe[p] = cfg_q[c].oe;
               drive_d.sel[p] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_drive <= '0;
      end else begin
         pin_drive <= drive_d;
      end
   end

   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (cpx_hit) begin
         case (addr_q[3:0])
            OFS_CPX_STATUS: begin
               rd_mux[ST_EN_BIT] = cfg_q[cpx_idx].en;
               rd_mux[ST_CLK_BIT] = cfg_q[cpx_idx].clk_sel;
               rd_mux[ST_OUT_BIT] = cfg_q[cpx_idx].out;
               rd_mux[ST_OE_BIT] = cfg_q[cpx_idx].oe;
               rd_mux[ST_IN_BIT] = cpx_in[cpx_idx];
               rd_mux[ST_MODE_LSB +: 4] = cfg_q[cpx_idx].mode;
               rd_mux[ST_PIN_LSB +: 6] = cfg_q[cpx_idx].pin;
            end
            OFS_CPX_THRESH: rd_mux = thr_q[cpx_idx];
            OFS_CPX_PERIOD: rd_mux = per_q[cpx_idx];
            default: rd_mux = 32'h0000_0000;
         endcase
      end else begin
         case (addr_q)
            OFS_POWER: begin
               rd_mux[PWR_REQ_BIT] = pwr_q;
               rd_mux[PWR_ACT_BIT] = act_q;
            end
            OFS_CONFIG: begin
               rd_mux[CFG_EN_BIT] = en_q;
               rd_mux[CFG_DIV_LSB +: 2] = div_sel_q;
               rd_mux[CFG_SLOW_LSB +: 8] = slow_div_q;
            end
            OFS_OUT_LO: rd_mux = out_q[31:0];
            OFS_OUT_HI: rd_mux[NPIN-33:0] = out_q[NPIN-1:32];
            OFS_OE_LO: rd_mux = oe_q[31:0];
            OFS_OE_HI: rd_mux[NPIN-33:0] = oe_q[NPIN-1:32];
            OFS_IN_LO: rd_mux = smp_q[31:0];
            OFS_IN_HI: rd_mux[NPIN-33:0] = smp_q[NPIN-1:32];
            OFS_IEN_LO: rd_mux = ien_q[31:0];
            OFS_IEN_HI: rd_mux[NPIN-33:0] = ien_q[NPIN-1:32];
            OFS_ISTAT_LO: rd_mux = istat_q[31:0];
            OFS_ISTAT_HI: rd_mux[NPIN-33:0] = istat_q[NPIN-1:32];
            OFS_OVR_LO: rd_mux = ovr_q[31:0];
            OFS_OVR_HI: rd_mux[NPIN-33:0] = ovr_q[NPIN-1:32];
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

endmodule

`default_nettype wire

// *** gpio_pkg.sv ***
// Constants, types and register map of the pin core
package gpio_pkg;

   // ------------------------------------------------------------------
   // Sizes and clocking
   // ------------------------------------------------------------------
   localparam int NPIN = 61;
   localparam int NCH = 8;
   localparam int TW = 32;
   localparam int CLK_HZ = 40_000_000;
   localparam int SLOW_MAX_HZ = 1_000_000;
   // Least terminal count that keeps the slow clock at or below its limit
   localparam logic [7:0] SLOW_DIV_MIN = 8'((CLK_HZ + SLOW_MAX_HZ - 1) / SLOW_MAX_HZ - 1);

   // ------------------------------------------------------------------
   // Register offsets (byte addresses, low 12 bits)
   // ------------------------------------------------------------------
   localparam logic [11:0] OFS_POWER = 12'h000;
   localparam logic [11:0] OFS_CONFIG = 12'h004;
   localparam logic [11:0] OFS_OUT_LO = 12'h010;
   localparam logic [11:0] OFS_OUT_HI = 12'h014;
   localparam logic [11:0] OFS_OE_LO = 12'h018;
   localparam logic [11:0] OFS_OE_HI = 12'h01C;
   localparam logic [11:0] OFS_IN_LO = 12'h020;
   localparam logic [11:0] OFS_IN_HI = 12'h024;
   localparam logic [11:0] OFS_IEN_LO = 12'h028;
   localparam logic [11:0] OFS_IEN_HI = 12'h02C;
   localparam logic [11:0] OFS_ISTAT_LO = 12'h030;
   localparam logic [11:0] OFS_ISTAT_HI = 12'h034;
   localparam logic [11:0] OFS_OVR_LO = 12'h038;
   localparam logic [11:0] OFS_OVR_HI = 12'h03C;
   // Complex pins: base 0x100, one 16-byte slot per channel
   localparam logic [3:0] CPX_PAGE = 4'h1;
   localparam logic [3:0] OFS_CPX_STATUS = 4'h0;
   localparam logic [3:0] OFS_CPX_TIMER = 4'h4;
   localparam logic [3:0] OFS_CPX_THRESH = 4'h8;
   localparam logic [3:0] OFS_CPX_PERIOD = 4'hC;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int PWR_ACT_BIT = 0;
   localparam int PWR_REQ_BIT = 31;
   localparam int CFG_EN_BIT = 0;
   localparam int CFG_DIV_LSB = 1;
   localparam int CFG_SLOW_LSB = 8;
   localparam int ST_EN_BIT = 0;
   localparam int ST_CLK_BIT = 1;
   localparam int ST_OUT_BIT = 2;
   localparam int ST_OE_BIT = 3;
   localparam int ST_IN_BIT = 4;
   localparam int ST_MODE_LSB = 8;
   localparam int ST_PIN_LSB = 16;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [1:0] DIV_SEL_RST = 2'h0;
   localparam logic [7:0] SLOW_DIV_RST = SLOW_DIV_MIN;
   localparam logic [TW-1:0] PERIOD_RST = {TW{1'b1}};

   // Plain-pin clock ratios 2, 4, 16, 64 as terminal counts
   localparam logic [5:0] DIV2_TC = 6'h01;
   localparam logic [5:0] DIV4_TC = 6'h03;
   localparam logic [5:0] DIV16_TC = 6'h0F;
   localparam logic [5:0] DIV64_TC = 6'h3F;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      static_mode = 4'h0,
      toggle_mode = 4'h1,
      snapshot_counter_mode = 4'h2,
      immediate_one_shot_mode = 4'h3,
      pulse_mode = 4'h4,
      pwm_mode = 4'h5,
      low_width_mode = 4'h6,
      high_width_mode = 4'h7,
      low_width_once = 4'h8,
      high_width_once = 4'h9,
      fall_edge_capture_mode = 4'hA,
      rise_edge_capture_mode = 4'hB,
      any_edge_capture_mode = 4'hC,
      fall_edge_single_capture = 4'hD,
      rise_edge_single_capture = 4'hE,
      any_edge_single_capture = 4'hF
   } mode_t;

   typedef struct packed {
      logic [5:0] pin;
      mode_t mode;
      logic oe;
      logic out;
      logic clk_sel;
      logic en;
   } cpx_cfg_t;

   typedef struct packed {
      logic [NPIN-1:0] out;
      logic [NPIN-1:0] oe;
      logic [NPIN-1:0] sel;
   } pin_drive_t;

endpackage

// *** gpio_core_with_timer_pins_monitor.sv ***
// Port checker for the pin core
`timescale 1ns/10ps
`default_nettype none
module gpio_core_with_timer_pins_monitor #(
   parameter int NPIN = gpio_pkg::NPIN,
   parameter int NCH = gpio_pkg::NCH
) (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset
   input wire logic hsel, // Select
   input wire logic [1:0] htrans, // Type
   input wire logic hwrite, // Write
   input wire logic hready, // Ready in
   input wire logic hreadyout, // Ready out
   input wire logic hresp, // Response
   input wire logic [31:0] hrdata, // Read data
   input wire gpio_pkg::pin_drive_t pin_drive, // Drive
   input wire logic irq // Interrupt
);
   logic acc;
   logic wdp_q;
   logic seen_q;
   assign acc = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdp_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         wdp_q <= acc && hwrite;
         seen_q <= seen_q || (acc && hwrite);
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rd; !hreadyout ##1 hreadyout; endsequence
   property p_rd; acc && !hwrite |=> s_rd; endproperty
   a_rd: assert property (p_rd) else $error("read wait wrong");
   property p_wr; acc && hwrite |=> hreadyout; endproperty
   a_wr: assert property (p_wr) else $error("write waited");
   property p_ok; hresp == 1'b0; endproperty
   a_ok: assert property (p_ok) else $error("bad response");
   property p_why; !hreadyout |-> $past(acc && !hwrite); endproperty
   a_why: assert property (p_why) else $error("stray wait");
   property p_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_off; !seen_q |-> pin_drive == '0 && !irq; endproperty
   a_off: assert property (p_off) else $error("active before setup");
   property p_irqf; $fell(irq) |-> $past(wdp_q, 2) || $past(wdp_q, 3); endproperty
   a_irqf: assert property (p_irqf) else $error("irq fell alone");
   property p_irqr; $rose(irq) |-> seen_q; endproperty
   a_irqr: assert property (p_irqr) else $error("irq without enable");
endmodule
bind gpio_core_with_timer_pins gpio_core_with_timer_pins_monitor #(.NPIN(NPIN), .NCH(NCH)) u_mon (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .pin_drive(pin_drive), .irq(irq));
`default_nettype wire

// *** pin_partner.sv ***
// Far-side pins: driven pins loop back, others show the external level
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
   input wire gpio_pkg::pin_drive_t drv, // Core drive
   input wire logic [60:0] ext, // External level
   output logic [60:0] pins // Level seen
);
   assign pins = (drv.sel & drv.oe & drv.out) | (~(drv.sel & drv.oe) & ext);
endmodule
`default_nettype wire

// *** tb_gpio_core_with_timer_pins.sv ***
// Bench for the pin core
`timescale 1ns/10ps
`default_nettype none
module tb_gpio_core_with_timer_pins;
   import gpio_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hrdy, irq;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [60:0] ext = 0, pins;
   pin_drive_t drv;
   int failures = 0, comparisons = 0, cyc = 0, n;
   always #12.5 hclk = ~hclk;
   gpio_core_with_timer_pins u_gpio_core_with_timer_pins (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(), .hrdata(hrdata),
      .pin_in(pins), .pin_drive(drv), .irq(irq));
   pin_partner u_pin_partner (.drv(drv), .ext(ext), .pins(pins));
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {20'h0_0000, a};
      do @(posedge hclk); while (hrdy !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic report_and_stop;
      if (failures == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 6000) begin
         failures++;
         report_and_stop();
      end
   end
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(drv.oe[31:0] | drv.sel[31:0] | drv.out[31:0], 32'h0000_0000);
      bus(1'b1, OFS_POWER, 32'h8000_0000);
      bus(1'b0, OFS_POWER, 32'h0000_0000);
      chk(rd, 32'h8000_0001);
      bus(1'b0, OFS_CONFIG, 32'h0000_0000);
      chk(rd, {16'h0000, SLOW_DIV_RST, 5'h00, DIV_SEL_RST, 1'b0});
      bus(1'b1, 12'h040, 32'hFFFF_FFFF);
      bus(1'b0, 12'h040, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b1, OFS_OVR_LO, 32'h0000_0020);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, OFS_CONFIG, 32'h0000_2701 | (32'(i) << CFG_DIV_LSB));
         bus(1'b1, OFS_OE_LO, 32'h0000_0020);
         bus(1'b1, OFS_OUT_LO, {26'h0, i[0], 5'h00});
         repeat (150) @(posedge hclk);
         chk({31'h0, drv.out[5]}, {31'h0, i[0]});
         bus(1'b0, OFS_IN_LO, 32'h0000_0000);
         chk(rd & 32'h0000_0020, {26'h0, i[0], 5'h00});
      end
      bus(1'b1, OFS_IEN_HI, 32'h0000_0100);
      ext[40] <= 1'b1;
      repeat (150) @(posedge hclk);
      chk({31'h0, irq}, 32'h0000_0001);
      bus(1'b1, OFS_ISTAT_HI, 32'h0000_0100);
      repeat (4) @(posedge hclk);
      chk({31'h0, irq}, 32'h0000_0000);
      bus(1'b1, 12'h10C, 32'h0000_0009);
      bus(1'b1, 12'h108, 32'h0000_0003);
      bus(1'b1, 12'h100, 32'h0032_0509);
      n = 0;
      repeat (100) begin
         @(posedge hclk);
         n += drv.out[50];
      end
      chk(32'(n >= 27 && n <= 33), 32'h0000_0001);
      bus(1'b1, 12'h13C, 32'h0000_0003);
      bus(1'b1, 12'h138, 32'h0000_0002);
      bus(1'b1, 12'h130, 32'h0033_0109);
      n = 0;
      repeat (100) begin
         @(posedge hclk);
         n += drv.out[51];
      end
      chk(32'(n >= 46 && n <= 54), 32'h0000_0001);
      bus(1'b1, 12'h108, 32'h0000_0005);
      bus(1'b1, 12'h100, 32'h0032_0309);
      repeat (3) @(posedge hclk);
      chk({31'h0, drv.out[50]}, 32'h0000_0001);
      repeat (30) @(posedge hclk);
      bus(1'b0, 12'h100, 32'h0000_0000);
      chk(rd & 32'h0000_0F04, 32'h0000_0000);
      bus(1'b1, 12'h114, 32'h0000_0000);
      bus(1'b1, 12'h110, 32'h002D_0E01);
      repeat (20) @(posedge hclk);
      ext[45] <= 1'b1;
      repeat (10) @(posedge hclk);
      bus(1'b0, 12'h110, 32'h0000_0000);
      chk(rd & 32'h0000_0F00, 32'h0000_0000);
      bus(1'b0, 12'h118, 32'h0000_0000);
      chk(32'(rd > 20 && rd < 40), 32'h0000_0001);
      bus(1'b1, OFS_CONFIG, 32'h0000_0507);
      bus(1'b1, 12'h120, 32'h0000_0203);
      repeat (400) @(posedge hclk);
      bus(1'b0, 12'h128, 32'h0000_0000);
      chk(32'(rd >= 9 && rd <= 11), 32'h0000_0001);
      report_and_stop();
   end
endmodule
`default_nettype wire
